// file: design/iobpg_arbiter.sv
`timescale 1ns/1ps
module iobpg_arbiter (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  // bus requests, sampled at io_sync
  input  wire logic                          io_sync,
  input  wire iobpg_pkg::iobpg_req_t         bus_req,
  // processor side acknowledge and release
  input  wire logic                          accept,
  input  wire logic                          done,
  // add-to-memory operands and cycle
  input  wire logic [1:0]                    add_cycle,
  input  wire logic [iobpg_pkg::IOBPG_WORD-1:0] add_a,
  input  wire logic [iobpg_pkg::IOBPG_WORD-1:0] add_b,
  // bus outputs
  output logic [iobpg_pkg::IOBPG_LEVELS-1:0] interrupt_chain_enable,
  output logic                               channel_chain_enable,
  output iobpg_pkg::iobpg_grant_t            grant,
  output iobpg_pkg::iobpg_xfer_t             xfer_kind,
  output logic                               add_overflow_flag,
  output logic                               busy
);
  import iobpg_pkg::*;

  // chains are steady levels; no break inside the processor
  assign interrupt_chain_enable = '1; // see RULE5
  assign channel_chain_enable   = 1'h1; // see RULE5

  // request decode, active-low pins turned round
  wire logic [IOBPG_LEVELS-1:0] intr_req = ~bus_req.intr_req_b;
  wire logic chan_req = ~bus_req.chan_req_b;
  wire logic one_req  = ~bus_req.one_cycle_req_b;

  // pairing of the two channel pins into a transfer kind
  function automatic iobpg_xfer_t kind_of(input logic c, input logic s);
    case ({c, s})
      2'h2:    kind_of = IOBPG_XFER_MULTI; // see RULE13
      2'h3:    kind_of = IOBPG_XFER_IN1;   // see RULE14
      2'h1:    kind_of = IOBPG_XFER_OUT1;  // see RULE17
      default: kind_of = IOBPG_XFER_NONE;
    endcase
  endfunction

  // fixed priority, lowest index wins; a level is picked only when
  // no level above it requests, so ties never yield two grants
  logic [IOBPG_LEVELS-1:0] intr_pick;
  logic [IOBPG_LEVELS-1:0] intr_above;
  genvar lv;
  generate
    for (lv = 0; lv < IOBPG_LEVELS; lv++) begin : g_pick
      if (lv == 0) begin : g_top
        assign intr_above[lv] = 1'h0;
      end else begin : g_rest
        assign intr_above[lv] = intr_above[lv-1] | intr_req[lv-1];
      end
      assign intr_pick[lv] = intr_req[lv] & ~intr_above[lv]; // see RULE2
    end
  endgenerate

  // channel service outranks interrupts; a channel request standing at every take keeps interrupts from ever being granted
  wire logic chan_any = chan_req | one_req;
  wire logic take = io_sync & accept & ~busy;
  iobpg_grant_t next_grant;
  assign next_grant.chan_grant = chan_any; // see RULE10
  assign next_grant.intr_grant = chan_any ? '0 : intr_pick;

  // grant stands from acceptance until the processor ends the service
  // done wins over a take in the same cycle; requests while busy are dropped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      grant     <= '0;
      xfer_kind <= IOBPG_XFER_NONE;
      busy      <= 1'h0;
    end else if (done) begin
      grant     <= '0;
      xfer_kind <= IOBPG_XFER_NONE;
      busy      <= 1'h0;
    end else if (take && (chan_any || |intr_req)) begin
      grant     <= next_grant;
      xfer_kind <= kind_of(chan_req, one_req);
      busy      <= 1'h1;
    end
  end

  // one's complement overflow: like signs in, other sign out
  logic [IOBPG_WORD:0] raw_sum;
  logic [IOBPG_WORD-1:0] sum;
  assign raw_sum = {1'b0, add_a} + {1'b0, add_b};
  assign sum = raw_sum[IOBPG_WORD-1:0] + {{(IOBPG_WORD-1){1'h0}}, raw_sum[IOBPG_WORD]};
  wire logic ovf = (add_a[IOBPG_SIGN] == add_b[IOBPG_SIGN]) &&
                   (sum[IOBPG_SIGN] != add_a[IOBPG_SIGN]);
  wire logic ovf_cycle = busy && (xfer_kind == IOBPG_XFER_MULTI) &&
                         (add_cycle == IOBPG_ADD_CYCLE);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      add_overflow_flag <= 1'h0;
    end else begin
      add_overflow_flag <= ovf_cycle & ovf; // see RULE3
    end
  end

  // checks on the grant path, the decode and the overflow flag

  // never two grants at once
  chk_grant_onehot: assert property (@(posedge clk) disable iff (!rst_b) // see RULE2
    $onehot0({grant.intr_grant, grant.chan_grant}))
    else $error("more than one grant active");

  // level zero beats every other level
  chk_intr_priority: assert property (@(posedge clk) disable iff (!rst_b) // see RULE2
    (take && !chan_any && !done && intr_req[0]) |=> grant.intr_grant[0])
    else $error("level zero not granted first");

  // level one wins when level zero is quiet
  chk_intr_second: assert property (@(posedge clk) disable iff (!rst_b) // see RULE2
    (take && !chan_any && !done && !intr_req[0] && intr_req[1]) |=> grant.intr_grant[1])
    else $error("level one not granted");

  // level two wins when the two above are quiet
  chk_intr_third: assert property (@(posedge clk) disable iff (!rst_b) // see RULE2
    (take && !chan_any && !done && intr_req[1:0] == 2'h0 && intr_req[2]) |=> grant.intr_grant[2])
    else $error("level two not granted");

  // level three only when it alone requests
  chk_intr_last: assert property (@(posedge clk) disable iff (!rst_b) // see RULE2
    (take && !chan_any && !done && intr_req[2:0] == 3'h0 && intr_req[3]) |=> grant.intr_grant[3])
    else $error("level three not granted");

  // a level is granted only if it asked
  chk_intr_requested: assert property (@(posedge clk) disable iff (!rst_b) // see RULE2
    (take && !chan_any && !done) |=> (grant.intr_grant & ~$past(intr_req)) == '0)
    else $error("unrequested level granted");

  // channel request is acknowledged by the grant
  chk_chan_grant: assert property (@(posedge clk) disable iff (!rst_b) // see RULE10
    (take && chan_any && !done) |=> grant.chan_grant && busy)
    else $error("channel request not granted");

  // channel service shuts out interrupt grants
  chk_chan_first: assert property (@(posedge clk) disable iff (!rst_b) // see RULE10
    (take && chan_any && !done) |=> grant.intr_grant == '0)
    else $error("interrupt granted over channel");

  // a grant stands while busy; new requests are refused
  chk_grant_hold: assert property (@(posedge clk) disable iff (!rst_b) // see RULE10
    (busy && !done) |=> $stable(grant) && $stable(xfer_kind))
    else $error("grant changed during service");

  // done ends the service on the next edge
  chk_done_clear: assert property (@(posedge clk) disable iff (!rst_b) // see RULE10
    done |=> !busy && grant == '0 && xfer_kind == IOBPG_XFER_NONE)
    else $error("service not released by done");

  // no grant shown while idle
  chk_idle_quiet: assert property (@(posedge clk) disable iff (!rst_b) // see RULE10
    !busy |-> grant == '0)
    else $error("grant shown while idle");

  // without a take the processor stays idle
  chk_no_take: assert property (@(posedge clk) disable iff (!rst_b) // see RULE10
    (!busy && !take) |=> !busy)
    else $error("grant without sync and accept");

  // both channel pins mean single cycle input
  chk_kind_in: assert property (@(posedge clk) disable iff (!rst_b) // see RULE14
    (take && chan_req && one_req && !done) |=> xfer_kind == IOBPG_XFER_IN1)
    else $error("input single cycle misdecoded");

  // channel pin alone means multicycle family
  chk_kind_multi: assert property (@(posedge clk) disable iff (!rst_b) // see RULE13
    (take && chan_req && !one_req && !done) |=> xfer_kind == IOBPG_XFER_MULTI)
    else $error("multicycle misdecoded");

  // one-cycle pin alone means single cycle output
  chk_kind_out: assert property (@(posedge clk) disable iff (!rst_b) // see RULE17
    (take && !chan_req && one_req && !done) |=> xfer_kind == IOBPG_XFER_OUT1)
    else $error("output single cycle misdecoded");

  // flag only after a qualifying third add cycle
  chk_ovf_cycle: assert property (@(posedge clk) disable iff (!rst_b) // see RULE3
    add_overflow_flag |-> $past(ovf_cycle) && $past(ovf))
    else $error("overflow flagged outside third add cycle");

  // every qualifying overflow is flagged
  chk_ovf_set: assert property (@(posedge clk) disable iff (!rst_b) // see RULE3
    (ovf_cycle && ovf) |=> add_overflow_flag)
    else $error("overflow not flagged");

  // flag needs operands of like sign
  chk_ovf_like: assert property (@(posedge clk) disable iff (!rst_b) // see RULE3
    add_overflow_flag |-> $past(add_a[IOBPG_SIGN]) == $past(add_b[IOBPG_SIGN]))
    else $error("overflow flagged for unlike signs");

  // chains are steady levels from the processor
  chk_chain_level: assert property (@(posedge clk) disable iff (!rst_b) // see RULE5
    channel_chain_enable && &interrupt_chain_enable)
    else $error("chain enable dropped by processor");

endmodule

// file: design/iobpg_pkg.sv
// Operation
// RULE1: peripheral asserts one of four active-low interrupt requests at sync time
// RULE2: processor ranks interrupt line 0 highest, then 1, 2, 3
// RULE3: third add-to-memory cycle flags overflow when like signs sum to opposite sign
// RULE4: peripheral samples the overflow flag to learn its stored sum is wrong
// RULE5: processor sources channel enable as a steady level daisy chained along bus
// RULE6: each peripheral may break the channel chain for all that follow
// RULE7: peripheral takes enable on chain input and passes it on chain output
// RULE8: peripheral requests a channel only while its incoming enable is true
// RULE9: requesting peripheral drops downstream enable at once; position resolves ties; the stand-in drops it on a channel request only
// RULE10: processor asserts channel grant when it acknowledges a channel request
// RULE11: granted peripheral drives word count address for three-cycle transfers
// RULE12: granted peripheral drives memory address for one-cycle transfers
// RULE13: channel request alone means multicycle, increment or add-to-memory
// RULE14: channel request with one-cycle request means single-cycle input transfer
// RULE15: peripheral places interrupt entry address on bus upon interrupt grant
// RULE16: each interrupt level has its own chain enable gating requests
// RULE17: one-cycle request without channel request means outgoing single-cycle transfer
// RULE18: granted peripheral releases request and restores chain after acceptance
package iobpg_pkg;
  localparam int IOBPG_LEVELS = 4;
  localparam int IOBPG_WORD   = 18;
  localparam int IOBPG_SIGN   = IOBPG_WORD - 1;
  localparam logic [1:0] IOBPG_ADD_CYCLE = 2'h2; // third cycle, counted from zero

  typedef enum logic [1:0] {
    IOBPG_XFER_NONE,
    IOBPG_XFER_OUT1,
    IOBPG_XFER_MULTI,
    IOBPG_XFER_IN1
  } iobpg_xfer_t;

  // active-low request pins as seen on the bus
  typedef struct packed {
    logic [IOBPG_LEVELS-1:0] intr_req_b;
    logic                    chan_req_b;
    logic                    one_cycle_req_b;
  } iobpg_req_t;

  typedef struct packed {
    logic [IOBPG_LEVELS-1:0] intr_grant;
    logic                    chan_grant;
  } iobpg_grant_t;
endpackage

// file: tb/iobpg_periph.sv
`timescale 1ns/1ps
// peripheral stand-in: requests gated by the incoming chains
module iobpg_periph (
  // chains from processor
  input  wire logic       chan_in,
  input  wire logic [3:0] intr_in,
  // wanted service
  input  wire logic       want_chan,
  input  wire logic       want_one,
  input  wire logic [3:0] want_intr,
  // grant and transfer kind from processor
  input  wire iobpg_pkg::iobpg_grant_t grant_in,
  input  wire iobpg_pkg::iobpg_xfer_t  kind_in,
  // bus side
  output iobpg_pkg::iobpg_req_t bus_req,
  output logic            chan_out,
  output logic [2:0]      addr_src
);
  import iobpg_pkg::*;
  // active low, posted only while the chain is live
  assign bus_req.intr_req_b = ~(want_intr & intr_in);
  assign bus_req.chan_req_b = ~(want_chan & chan_in);
  assign bus_req.one_cycle_req_b = ~(want_one & chan_in);
  // a channel request cuts off everyone further down; a one-cycle request alone leaves chan_out high
  assign chan_out = chan_in & ~want_chan;
  // address put on the bus once granted: 1 entry, 2 word count, 4 memory
  wire logic entry = |(grant_in.intr_grant & want_intr);
  assign addr_src = !grant_in.chan_grant ? {2'h0, entry} :
                    (kind_in == IOBPG_XFER_MULTI) ? 3'h2 : 3'h4;
endmodule

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  import iobpg_pkg::*;
  logic clk, rst_b, io_sync, accept, done, wc, wo, cout, cce, ovf, busy;
  logic [1:0] cy;
  logic [2:0] src;
  logic [3:0] wi, ice;
  logic [IOBPG_WORD-1:0] a, b;
  logic [31:0] r;
  iobpg_req_t req;
  iobpg_grant_t gnt;
  iobpg_xfer_t kind;
  int err_total, cmp_count;
  iobpg_arbiter dut (.clk(clk), .rst_b(rst_b), .io_sync(io_sync), .bus_req(req),
    .accept(accept), .done(done), .add_cycle(cy), .add_a(a), .add_b(b),
    .interrupt_chain_enable(ice), .channel_chain_enable(cce), .grant(gnt),
    .xfer_kind(kind), .add_overflow_flag(ovf), .busy(busy));
  iobpg_periph per (.chan_in(cce), .intr_in(ice), .want_chan(wc), .want_one(wo),
    .want_intr(wi), .grant_in(gnt), .kind_in(kind), .bus_req(req), .chan_out(cout),
    .addr_src(src));
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  task automatic chk(string what, logic [11:0] exp, logic [11:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // channel outranks interrupts, level 0 first
  function automatic logic [4:0] exp_gnt(logic c, logic o, logic [3:0] i);
    if (c | o) return 5'h01;
    for (int k = 0; k < 4; k++) if (i[k]) return 5'h02 << k;
    return 5'h00;
  endfunction
  // granted peripheral address: word count, memory address or entry
  function automatic logic [2:0] exp_src(logic c, logic o, logic [3:0] i);
    if (c | o) return (c && !o) ? 3'h2 : 3'h4;
    return (i != 4'h0) ? 3'h1 : 3'h0;
  endfunction
  function automatic logic [1:0] exp_kind(logic c, logic o);
    if (!(c | o)) return IOBPG_XFER_NONE;
    return c ? (o ? IOBPG_XFER_IN1 : IOBPG_XFER_MULTI) : IOBPG_XFER_OUT1;
  endfunction
  // end-around carry sum of like signs flipping sign
  function automatic logic exp_ovf(logic [17:0] x, logic [17:0] y);
    logic [18:0] s;
    s = x + y;
    s = s[17:0] + s[18];
    return x[17] == y[17] && s[17] != x[17];
  endfunction
  task automatic xfer(logic c, logic o, logic [3:0] i, logic [1:0] n, logic [17:0] x, y);
    {wc, wo, wi, io_sync, accept} = {c, o, i, 2'b11};
    @(negedge clk);
    {io_sync, accept} = 2'b00;
    chk("grant", exp_gnt(c, o, i), gnt);
    chk("kind", exp_kind(c, o), kind);
    chk("chain out", {11'h000, !c}, cout);
    chk("address source", exp_src(c, o, i), src);
    {a, b, cy} = {x, y, n};
    @(negedge clk);
    chk("overflow", exp_ovf(x, y) && n == IOBPG_ADD_CYCLE && c && !o, ovf);
    {cy, done, wc, wo, wi} = 9'h040;
    @(negedge clk);
    done = 0;
    chk("release", 12'h000, {gnt, busy, ovf});
    chk("chains", 12'h01f, {ice, cce});
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    {rst_b, io_sync, accept, done, wc, wo, wi, cy, a, b} = 0;
    err_total = 0;
    cmp_count = 0;
    void'($urandom(8));
    repeat (10) @(negedge clk);
    rst_b = 1;
    chk("reset", 12'h000, {gnt, kind, ovf, busy});
    xfer(1, 0, 4'hf, 2, 18'h1ffff, 18'h00001);
    xfer(1, 0, 4'h0, 3, 18'h20000, 18'h20000);
    xfer(0, 0, 4'hf, 2, 18'h20000, 18'h20000);
    xfer(0, 0, 4'h8, 0, 0, 0);
    $display("corner test done");
    repeat (300) begin
      r = $urandom;
      xfer(r[0], r[1], r[5:2], r[7:6], 18'($urandom), 18'($urandom));
    end
    $display("random test done");
    conclude();
  end
  initial begin
    #100000;
    err_total++;
    conclude();
  end
endmodule
